// ### src/rpc_pkg.sv
// Purpose: constants and carrier types for the resolver phase counter
// Assumes: 200 MHz system clock, count clock enters as an asynchronous pin
// Notes: count clock edges are detected after a two-stage synchroniser
// Contract
// - count from one wave to another
// - advance once per 2.048 MHz cycle
// - start and stop on rising crossings
// - phase count never exceeds 2015, wraps zero
// - counter holds 2016 values
// - one count about 10.7 arc-minutes phase
// - fine scaling 5.35 arc-minutes shaft
// - coarse normal uses excitation reference start
// - backup mode counts between network phases
// - detector output high rising, low falling
// - monitor error low on lost amplitude
// - all error outputs go to sampler
// - 38 detector outputs, address selected
// - start suffix gates start, stop gates stop
// - latches ignore initial high level
`default_nettype none
package rpc_pkg;
  localparam int DETECTOR_COUNT = 38;
  localparam int SELECT_WIDTH = 6;
  localparam int COUNT_WIDTH = 11;
  localparam int MONITOR_COUNT = 19;
  localparam logic [COUNT_WIDTH-1:0] PHASE_COUNT_MAX = 11'h7DF;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 11'h000;
  localparam int COUNT_CLOCK_KHZ = 2048;
  localparam int SYSTEM_CLOCK_KHZ = 200000;
  localparam int ARCMIN_PHASE_PER_LSB_X100 = 1070;
  localparam int ARCMIN_SHAFT_PER_LSB_X100 = 535;
  localparam logic [SELECT_WIDTH-1:0] SELECT_RESET = 6'h00;
  // clocks after reset before the pin synchroniser shows real levels
  localparam logic [1:0] SYNC_SETTLE = 2'h2;

  typedef enum logic [4:0] {
    RPC_IDLE = 5'b00001,
    RPC_ARM_START = 5'b00010,
    RPC_WAIT_START = 5'b00100,
    RPC_ARM_STOP = 5'b01000,
    RPC_DONE = 5'b10000
  } rpc_state_t;

  typedef struct packed {
    logic start;
    logic [SELECT_WIDTH-1:0] start_select;
    logic [SELECT_WIDTH-1:0] stop_select;
  } rpc_request_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [COUNT_WIDTH-1:0] count;
  } rpc_result_t;
endpackage : rpc_pkg
`default_nettype wire

// ### src/rpc_sync.sv
// Purpose: two-flip-flop synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to clock_in
// Notes: only the second stage is visible
`default_nettype none
module rpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } rpc_sync_state_t;
  rpc_sync_state_t state;
  rpc_sync_state_t next_state;

  always_comb begin
    next_state.first = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;
endmodule : rpc_sync
`default_nettype wire

// ### src/rpc_counter.sv
// Purpose: resolver phase counter between two selected crossover outputs
// Assumes: detector square waves and count clock arrive as pins
// Notes: selects sampled when a start request is taken
`default_nettype none
module rpc_counter #(
  parameter int DETECTORS = rpc_pkg::DETECTOR_COUNT,
  parameter int MONITORS = rpc_pkg::MONITOR_COUNT
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic count_clock_in,
  input wire logic [DETECTORS-1:0] crossover_detector_in,
  input wire logic [MONITORS-1:0] amplitude_monitor_buffer_in,
  input wire rpc_pkg::rpc_request_t request_in,
  output rpc_pkg::rpc_result_t result_out,
  output logic [MONITORS-1:0] crossover_error_signal_out
);
  import rpc_pkg::*;

  logic [DETECTORS+MONITORS:0] pins_sync;

  // synchronise detector, monitor and count clock pins
  rpc_sync #(
    .WIDTH(DETECTORS + MONITORS + 1)
  ) pin_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in({count_clock_in, amplitude_monitor_buffer_in, crossover_detector_in}),
    .sync_out(pins_sync)
  );

  typedef struct packed {
    rpc_state_t fsm;
    logic [SELECT_WIDTH-1:0] start_sel;
    logic [SELECT_WIDTH-1:0] stop_sel;
    logic seen_low;
    logic clock_prev;
    logic [COUNT_WIDTH-1:0] count;
    logic busy;
    logic done;
    logic [MONITORS-1:0] errors;
    logic [1:0] settle;
  } rpc_core_t;

  rpc_core_t state;
  rpc_core_t next_state;

  function automatic logic [DETECTORS-1:0] decode(input logic [SELECT_WIDTH-1:0] sel);
    logic [DETECTORS-1:0] hot;
    hot = '0;
    for (int i = 0; i < DETECTORS; i++) begin
      if (int'(sel) == i) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction : decode

  logic [DETECTORS-1:0] waves;
  logic [DETECTORS-1:0] start_enable;
  logic [DETECTORS-1:0] stop_enable;
  wire logic [DETECTORS-1:0] start_gate;
  wire logic [DETECTORS-1:0] stop_gate;
  logic count_clock;
  logic start_level;
  logic stop_level;
  logic count_tick;

  always_comb begin
    waves = pins_sync[DETECTORS-1:0];
    count_clock = pins_sync[DETECTORS+MONITORS];
    start_enable = decode(state.start_sel);
    stop_enable = decode(state.stop_sel);
    count_tick = count_clock & ~state.clock_prev;
  end

  for (genvar g = 0; g < DETECTORS; g++) begin : gen_gate
    assign start_gate[g] = start_enable[g] & waves[g];
    assign stop_gate[g] = stop_enable[g] & waves[g];
  end

  // an address past the last detector enables no gate and reads low
  assign start_level = |start_gate;
  assign stop_level = |stop_gate;

  always_comb begin
    next_state = state;
    next_state.clock_prev = count_clock;
    // hold error lines high until the synchroniser shows real pin levels,
    // else its reset zeros would flag a false malfunction after reset
    if (state.settle != SYNC_SETTLE) begin
      next_state.settle = state.settle + 2'h1;
    end else begin
      next_state.errors = pins_sync[DETECTORS+MONITORS-1:DETECTORS];
    end
    unique case (state.fsm)
      RPC_IDLE, RPC_DONE: begin
        if (request_in.start) begin
          next_state.start_sel = request_in.start_select;
          next_state.stop_sel = request_in.stop_select;
          next_state.count = COUNT_RESET;
          next_state.seen_low = 1'b0;
          next_state.busy = 1'b1;
          next_state.done = 1'b0;
          next_state.fsm = RPC_ARM_START;
        end
      end
      RPC_ARM_START: begin
        next_state.fsm = RPC_WAIT_START;
      end
      RPC_WAIT_START: begin
        if (!start_level) begin
          next_state.seen_low = 1'b1;
        end else if (state.seen_low) begin
          next_state.seen_low = 1'b0;
          next_state.fsm = RPC_ARM_STOP;
        end
      end
      RPC_ARM_STOP: begin
        if (count_tick) begin
          next_state.count = state.count + 11'h001;
        end
        if (count_tick && state.count == PHASE_COUNT_MAX) begin
          next_state.count = COUNT_RESET;
        end
        if (!stop_level) begin
          next_state.seen_low = 1'b1;
        end else if (state.seen_low) begin
          next_state.count = state.count;
          next_state.busy = 1'b0;
          next_state.done = 1'b1;
          next_state.fsm = RPC_DONE;
        end
      end
      default: begin
        next_state.fsm = RPC_IDLE;
        next_state.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state.fsm <= RPC_IDLE;
      state.start_sel <= SELECT_RESET;
      state.stop_sel <= SELECT_RESET;
      state.seen_low <= 1'b0;
      state.clock_prev <= 1'b0;
      state.count <= COUNT_RESET;
      state.busy <= 1'b0;
      state.done <= 1'b0;
      state.errors <= '1;
      state.settle <= 2'h0;
    end else begin
      state <= next_state;
    end
  end

  assign result_out.busy = state.busy;
  assign result_out.done = state.done;
  assign result_out.count = state.count;
  assign crossover_error_signal_out = state.errors;
endmodule : rpc_counter
`default_nettype wire

// ### tb/rpc_checker_sva.sv
// Purpose: port assertions for rpc_counter
// Assumes: one clock domain
// Notes: bound below the module
`default_nettype none
module rpc_checker import rpc_pkg::*; #(
  parameter int MONITORS = 19
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire rpc_pkg::rpc_request_t request_in,
  input wire rpc_pkg::rpc_result_t result_out,
  input wire logic [MONITORS-1:0] amplitude_monitor_buffer_in,
  input wire logic [MONITORS-1:0] crossover_error_signal_out
);
  wire s = request_in.start;
  wire b = result_out.busy;
  wire d = result_out.done;
  wire [10:0] c = result_out.count;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_clr; s && !b |=> b && !d && c == COUNT_RESET; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_hold; d && !s |=> d && $stable(c); endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_max; c <= PHASE_COUNT_MAX; endproperty
  a_max: assert property (p_max) else $error("over limit");
  property p_inc;
    b && $past(b) && c != $past(c) |-> c == $past(c) + 11'h001 || c == 11'h000;
  endproperty
  a_inc: assert property (p_inc) else $error("bad step");
  property p_rate; b && $changed(c) |=> $stable(c); endproperty
  a_rate: assert property (p_rate) else $error("too fast");
  property p_fin; $fell(b) |-> d; endproperty
  a_fin: assert property (p_fin) else $error("no done");
  property p_one; !(b && d); endproperty
  a_one: assert property (p_one) else $error("busy and done");
  property p_err;
    $stable(amplitude_monitor_buffer_in) [*4] |->
      crossover_error_signal_out == amplitude_monitor_buffer_in;
  endproperty
  a_err: assert property (p_err) else $error("error out");
endmodule : rpc_checker
bind rpc_counter rpc_checker #(.MONITORS(MONITORS)) u_chk (
  .clock_in(clock_in), .reset_in(reset_in),
  .request_in(request_in), .result_out(result_out),
  .amplitude_monitor_buffer_in(amplitude_monitor_buffer_in),
  .crossover_error_signal_out(crossover_error_signal_out));
`default_nettype wire

// ### tb/rpc_resolver_model.sv
// Purpose: crossover detector waves
// Assumes: waves step on falling count clock
// Notes: wave k lags wave 0 by k counts
`default_nettype none
module rpc_resolver_model #(
  parameter int PERIOD = 32
) (
  input wire logic count_clock_in,
  output var logic [37:0] wave_out
);
  int t = 0;
  always @(negedge count_clock_in) t <= (t + 1) % PERIOD;
  always_comb begin
    for (int k = 0; k < 38; k++) wave_out[k] = ((t - k + 64) % PERIOD) < PERIOD / 2;
  end
endmodule : rpc_resolver_model
`default_nettype wire

// ### tb/testbench.sv
// Purpose: scenario bench for rpc_counter
// Assumes: model waves repeat every 32 counts
// Notes: wave k lags wave 0 by k counts
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rpc_pkg::*;
  logic clock_in = 1'b0;
  logic cclk = 1'b0;
  logic reset_in = 1'b1;
  logic [37:0] wave;
  logic [18:0] mon = 19'h7FFFF;
  logic [18:0] err;
  rpc_request_t req = '0;
  rpc_result_t res;
  int n_fail = 0;
  int n_compared = 0;
  initial forever #2.5 clock_in = ~clock_in;
  int cclk_half = 244;
  initial forever #(cclk_half) cclk = ~cclk;
  rpc_resolver_model model (.count_clock_in(cclk), .wave_out(wave));
  rpc_counter uut (.clock_in(clock_in), .reset_in(reset_in), .count_clock_in(cclk),
    .crossover_detector_in(wave), .amplitude_monitor_buffer_in(mon),
    .request_in(req), .result_out(res), .crossover_error_signal_out(err));
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %0t %s", $time, m);
    end
  endtask : check
  task automatic measure(input int a, input int b, input int e, input bit p);
    req = '{1'b1, 6'(a), 6'(b)};
    @(negedge clock_in);
    req.start = 1'b0;
    @(negedge clock_in);
    check(res.busy === 1'b1 && res.done === 1'b0 && res.count === 11'h000, "clear");
    req.start = p;
    req.stop_select = 6'h07;
    @(negedge clock_in);
    req.start = 1'b0;
    for (int i = 0; i < 9000 && res.done !== 1'b1; i++) @(negedge clock_in);
    check(res.count === 11'(e) && res.busy === 1'b0, "count");
  endtask : measure
  task automatic t_pairs;
    measure(0, 5, 5, 1'b0);
    measure(5, 0, 27, 1'b0);
    measure(2, 3, 1, 1'b0);
    measure(36, 1, 29, 1'b0);
    measure(30, 37, 7, 1'b0);
  endtask : t_pairs
  task automatic t_edge;
    repeat (300) @(negedge clock_in);
    check(res.done === 1'b1 && res.count === 11'h007, "hold");
    wait (wave[0] === 1'b1);
    @(negedge clock_in);
    measure(0, 5, 5, 1'b0);
    measure(0, 5, 5, 1'b1);
  endtask : t_edge
  task automatic t_wrap;
    cclk_half = 15;
    repeat (4) @(posedge cclk);
    @(negedge clock_in);
    measure(2, 9, 7, 1'b0);
    req = '{1'b1, 6'h00, 6'h3F};
    @(negedge clock_in);
    req.start = 1'b0;
    for (int i = 0; i < 20000 && res.count !== PHASE_COUNT_MAX; i++) @(negedge clock_in);
    check(res.count === PHASE_COUNT_MAX && res.busy === 1'b1, "top");
    for (int i = 0; i < 20 && res.count === PHASE_COUNT_MAX; i++) @(negedge clock_in);
    check(res.count === COUNT_RESET && res.busy === 1'b1, "wrap");
    reset_in = 1'b1;
    repeat (3) @(negedge clock_in);
    check(res.busy === 1'b0 && res.done === 1'b0 && res.count === COUNT_RESET, "abort");
    reset_in = 1'b0;
    repeat (2) begin
      @(negedge clock_in);
      check(err === 19'h7FFFF && res.busy === 1'b0, "settle");
    end
    measure(5, 0, 27, 1'b0);
    cclk_half = 244;
  endtask : t_wrap
  task automatic t_monitor;
    mon = 19'h2AAAA;
    repeat (5) @(negedge clock_in);
    check(err === 19'h2AAAA, "monitor");
    mon = 19'h7FFFF;
  endtask : t_monitor
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(negedge clock_in);
    reset_in = 1'b0;
    check(err === 19'h7FFFF && res.done === 1'b0, "reset");
    t_pairs();
    t_edge();
    t_wrap();
    t_monitor();
    test_done();
  end
  initial begin
    #450000;
    n_fail++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
